// *** rtl/rbr_regs.svh ***
`ifndef RBR_REGS_SVH
`define RBR_REGS_SVH

// ----------------------------------------------------------------------
// Command and reply codes
// ----------------------------------------------------------------------
`define RBR_OPCODE_BLOCK_READ 8'h72
`define RBR_ACK_TOP 2'h3
`define RBR_FLAGS_OK 5'h0B
`define RBR_FLAGS_FAIL 5'h00

// ----------------------------------------------------------------------
// Transponder layout
// ----------------------------------------------------------------------
`define RBR_BLOCK_PAGES 3'h4
`define RBR_SERIAL_PAGE 6'h00
`define RBR_CONFIG_PAGE 6'h01
`define RBR_ENC_FIRST_PAGE 6'h04
`define RBR_USER_FIRST_PAGE 6'h10
`define RBR_S_FIRST_PAGE 6'h02
`define RBR_S_SMALL_LAST_PAGE 6'h07

// ----------------------------------------------------------------------
// Authorisation list
// ----------------------------------------------------------------------
`define RBR_AUTH_END 32'hFFFFFFFF

`endif

// *** rtl/rbr_pkg.sv ***
package rbr_pkg;

    typedef logic [5:0] rbr_page_t;

    typedef enum logic [2:0] {
        DEV_IDLE,
        DEV_ARG,
        DEV_AUTH,
        DEV_FETCH,
        DEV_ACK,
        DEV_DATA
    } rbr_dev_state_e;

    typedef enum logic [2:0] {
        HOST_IDLE,
        HOST_CMD,
        HOST_ARG,
        HOST_ACK,
        HOST_DATA
    } rbr_host_state_e;

endpackage : rbr_pkg

// *** rtl/rbr_link_if.sv ***
`timescale 1ns/10ps
interface rbr_link_if;
    logic [7:0] hostByte;
    logic hostValid;
    logic devReady;
    logic [7:0] devByte;
    logic devValid;
    logic hostReady;

    modport dev (
        input hostByte,
        input hostValid,
        input hostReady,
        output devReady,
        output devByte,
        output devValid
    );

    modport host (
        output hostByte,
        output hostValid,
        output hostReady,
        input devReady,
        input devByte,
        input devValid
    );
endinterface : rbr_link_if

// *** rtl/rbr_reader_end.sv ***
`timescale 1ns/10ps
`include "rbr_regs.svh"

module rbr_reader_end (
    // Clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Host link
    rbr_link_if.dev link,
    // Transponder access
    output logic tagReq,
    output logic [5:0] tagPage,
    input wire logic tagAck,
    input wire logic tagOk,
    input wire logic [31:0] tagData,
    // Nonvolatile settings
    input wire logic encOn,
    input wire logic [31:0] seed,
    input wire logic authWr,
    input wire logic [1:0] authIdx,
    input wire logic [31:0] authCode,
    // Status
    output logic busy,
    output logic authFail
);
    localparam int AUTH_N = 4;

    rbr_pkg::rbr_dev_state_e state_r, state_nxt;
    rbr_pkg::rbr_page_t page_r, page_nxt;
    rbr_pkg::rbr_page_t tagPage_r, tagPage_nxt;
    logic [31:0] serial_r, serial_nxt;
    logic [2:0] idx_r, idx_nxt;
    logic [3:0] byteIdx_r, byteIdx_nxt;
    logic ok_r, ok_nxt;
    logic tagReq_r, tagReq_nxt;
    logic devReady_r, devReady_nxt;
    logic devValid_r, devValid_nxt;
    logic [7:0] devByte_r, devByte_nxt;
    logic authFail_r, authFail_nxt;
    logic busy_r;
    logic [31:0] buf_r [0:3];
    logic [31:0] authList_r [0:AUTH_N-1];
    logic authOk;
    logic listEnded;

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    wire logic hostTake = link.hostValid && devReady_r;
    wire logic devSent = devValid_r && link.hostReady;
    wire logic isOpcode = link.hostByte == `RBR_OPCODE_BLOCK_READ;
    wire logic [2:0] pageCnt = `RBR_BLOCK_PAGES - {1'b0, page_r[1:0]};
    wire logic [5:0] curPage = page_r + {3'h0, idx_r};
    wire logic lastFetch = (idx_r + 3'h1) == pageCnt;
    // Pages zero to three keep serial and configuration readable by anyone.
    wire logic encPage = encOn && (curPage >= `RBR_ENC_FIRST_PAGE);
    wire logic [31:0] keyStream = seed ^ {serial_r[15:0], serial_r[31:16]}
        ^ {4{2'h0, curPage}};
    wire logic [31:0] plainData = encPage ? (tagData ^ keyStream) : tagData;
    wire logic [7:0] ackOk = {`RBR_ACK_TOP, `RBR_FLAGS_OK, 1'b0};
    wire logic [7:0] ackFail = {`RBR_ACK_TOP, `RBR_FLAGS_FAIL, 1'b0};
    wire logic [3:0] byteNext = byteIdx_r + 4'h1;
    wire logic [31:0] nextWord = buf_r[byteNext[3:2]];
    wire logic [7:0] nextByte = (byteNext[1:0] == 2'h0) ? nextWord[31:24] :
                                (byteNext[1:0] == 2'h1) ? nextWord[23:16] :
                                (byteNext[1:0] == 2'h2) ? nextWord[15:8] :
                                nextWord[7:0];
    wire logic lastByte = ({1'b0, byteIdx_r[3:2]} == (pageCnt - 3'h1))
        && (byteIdx_r[1:0] == 2'h3);
    wire logic bufWe = (state_r == rbr_pkg::DEV_FETCH) && tagAck && tagOk;

    // ------------------------------------------------------------------
    // Authorisation list match
    // ------------------------------------------------------------------
    // An all-ones first entry means an empty list, which admits every tag.
    always_comb begin
        authOk = authList_r[0] == `RBR_AUTH_END;
        listEnded = 1'b0;
        for (int i = 0; i < AUTH_N; i++) begin
            if (authList_r[i] == `RBR_AUTH_END) begin
                listEnded = 1'b1;
            end else if (!listEnded && authList_r[i] == tagData) begin
                authOk = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        page_nxt = page_r;
        tagPage_nxt = tagPage_r;
        serial_nxt = serial_r;
        idx_nxt = idx_r;
        byteIdx_nxt = byteIdx_r;
        ok_nxt = ok_r;
        tagReq_nxt = tagReq_r;
        devReady_nxt = devReady_r;
        devValid_nxt = devValid_r;
        devByte_nxt = devByte_r;
        authFail_nxt = authFail_r;
        case (state_r)
            rbr_pkg::DEV_IDLE: begin
                devReady_nxt = 1'b1;
                if (hostTake && isOpcode) begin
                    state_nxt = rbr_pkg::DEV_ARG;
                end
            end
            rbr_pkg::DEV_ARG: begin
                if (hostTake) begin
                    page_nxt = link.hostByte[5:0];
                    devReady_nxt = 1'b0;
                    tagReq_nxt = 1'b1;
                    tagPage_nxt = `RBR_SERIAL_PAGE;
                    state_nxt = rbr_pkg::DEV_AUTH;
                end
            end
            rbr_pkg::DEV_AUTH: begin
                if (tagAck) begin
                    if (tagOk && authOk) begin
                        serial_nxt = tagData;
                        authFail_nxt = 1'b0;
                        idx_nxt = 3'h0;
                        tagPage_nxt = page_r;
                        state_nxt = rbr_pkg::DEV_FETCH;
                    end else begin
                        tagReq_nxt = 1'b0;
                        authFail_nxt = tagOk;
                        ok_nxt = 1'b0;
                        devByte_nxt = ackFail;
                        devValid_nxt = 1'b1;
                        state_nxt = rbr_pkg::DEV_ACK;
                    end
                end
            end
            rbr_pkg::DEV_FETCH: begin
                if (tagAck) begin
                    if (!tagOk) begin
                        tagReq_nxt = 1'b0;
                        ok_nxt = 1'b0;
                        devByte_nxt = ackFail;
                        devValid_nxt = 1'b1;
                        state_nxt = rbr_pkg::DEV_ACK;
                    end else if (lastFetch) begin
                        // The whole block is gathered first so a late tag
                        // failure can still be reported as a bare acknowledge.
                        tagReq_nxt = 1'b0;
                        ok_nxt = 1'b1;
                        devByte_nxt = ackOk;
                        devValid_nxt = 1'b1;
                        state_nxt = rbr_pkg::DEV_ACK;
                    end else begin
                        idx_nxt = idx_r + 3'h1;
                        tagPage_nxt = curPage + 6'h01;
                    end
                end
            end
            rbr_pkg::DEV_ACK: begin
                if (devSent) begin
                    if (ok_r) begin
                        byteIdx_nxt = 4'h0;
                        devByte_nxt = buf_r[0][31:24];
                        state_nxt = rbr_pkg::DEV_DATA;
                    end else begin
                        devValid_nxt = 1'b0;
                        devReady_nxt = 1'b1;
                        state_nxt = rbr_pkg::DEV_IDLE;
                    end
                end
            end
            rbr_pkg::DEV_DATA: begin
                if (devSent) begin
                    if (lastByte) begin
                        devValid_nxt = 1'b0;
                        devReady_nxt = 1'b1;
                        state_nxt = rbr_pkg::DEV_IDLE;
                    end else begin
                        byteIdx_nxt = byteNext;
                        devByte_nxt = nextByte;
                    end
                end
            end
            default: begin
                state_nxt = rbr_pkg::DEV_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= rbr_pkg::DEV_IDLE;
            page_r <= 6'h00;
            tagPage_r <= 6'h00;
            serial_r <= 32'h00000000;
            idx_r <= 3'h0;
            byteIdx_r <= 4'h0;
            ok_r <= 1'b0;
            tagReq_r <= 1'b0;
            devReady_r <= 1'b0;
            devValid_r <= 1'b0;
            devByte_r <= 8'h00;
            authFail_r <= 1'b0;
            busy_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            page_r <= page_nxt;
            tagPage_r <= tagPage_nxt;
            serial_r <= serial_nxt;
            idx_r <= idx_nxt;
            byteIdx_r <= byteIdx_nxt;
            ok_r <= ok_nxt;
            tagReq_r <= tagReq_nxt;
            devReady_r <= devReady_nxt;
            devValid_r <= devValid_nxt;
            devByte_r <= devByte_nxt;
            authFail_r <= authFail_nxt;
            busy_r <= state_nxt != rbr_pkg::DEV_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // Page buffer and authorisation list storage
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < AUTH_N; i++) begin
                authList_r[i] <= `RBR_AUTH_END;
            end
            for (int i = 0; i < 4; i++) begin
                buf_r[i] <= 32'h00000000;
            end
        end else if (ce) begin
            if (authWr) begin
                authList_r[authIdx] <= authCode;
            end
            if (bufWe) begin
                buf_r[idx_r[1:0]] <= plainData;
            end
        end
    end

    assign link.devReady = devReady_r;
    assign link.devValid = devValid_r;
    assign link.devByte = devByte_r;
    assign tagReq = tagReq_r;
    assign tagPage = tagPage_r;
    assign busy = busy_r;
    assign authFail = authFail_r;
endmodule : rbr_reader_end

// *** rtl/rbr_host_end.sv ***
`timescale 1ns/10ps
`include "rbr_regs.svh"

module rbr_host_end (
    // Clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Host link
    rbr_link_if.host link,
    // Request
    input wire logic startReq,
    input wire logic [5:0] startPage,
    input wire logic famS,
    input wire logic famSLarge,
    // Results
    output logic busy,
    output logic [7:0] dataByte,
    output logic dataValid,
    output logic done,
    output logic readOk,
    output logic userPageWarn,
    output logic [7:0] blockReadOnly
);
    rbr_pkg::rbr_host_state_e state_r;
    rbr_pkg::rbr_page_t page_r;
    logic [3:0] byteIdx_r;
    logic hostValid_r;
    logic hostReady_r;
    logic [7:0] hostByte_r;
    logic busy_r;
    logic [7:0] dataByte_r;
    logic dataValid_r;
    logic done_r;
    logic readOk_r;
    logic warn_r;
    logic [7:0] lockRo_r;

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    wire logic sent = hostValid_r && link.devReady;
    wire logic got = hostReady_r && link.devValid;
    wire logic [7:0] rx = link.devByte;
    wire logic ackGood = (rx[7:6] == `RBR_ACK_TOP) && (rx[5:1] == `RBR_FLAGS_OK);
    wire logic [3:0] lastIdx = {2'h3 - page_r[1:0], 2'h3};
    wire logic [5:0] rxPage = page_r + {4'h0, byteIdx_r[3:2]};
    // Byte 0 of page 1 is the block lock byte; bytes 1 to 3 are plain data.
    wire logic isLockByte = (rxPage == `RBR_CONFIG_PAGE) && (byteIdx_r[1:0] == 2'h0);
    wire logic [7:0] lockRo = ~{rx[0], rx[1], rx[2], rx[3], rx[4], rx[5], rx[6], rx[7]};
    wire logic outOfUser = famS ? ((startPage < `RBR_S_FIRST_PAGE)
        || (!famSLarge && startPage > `RBR_S_SMALL_LAST_PAGE))
        : (startPage < `RBR_USER_FIRST_PAGE);

    // ------------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------------
    // Only reads are issued, so configuration page 1 is never rewritten.
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= rbr_pkg::HOST_IDLE;
            page_r <= 6'h00;
            byteIdx_r <= 4'h0;
            hostValid_r <= 1'b0;
            hostReady_r <= 1'b0;
            hostByte_r <= 8'h00;
            busy_r <= 1'b0;
            dataByte_r <= 8'h00;
            dataValid_r <= 1'b0;
            done_r <= 1'b0;
            readOk_r <= 1'b0;
            warn_r <= 1'b0;
            lockRo_r <= 8'h00;
        end else if (ce) begin
            dataValid_r <= 1'b0;
            done_r <= 1'b0;
            case (state_r)
                rbr_pkg::HOST_IDLE: begin
                    if (startReq) begin
                        page_r <= startPage;
                        warn_r <= outOfUser;
                        hostByte_r <= `RBR_OPCODE_BLOCK_READ;
                        hostValid_r <= 1'b1;
                        busy_r <= 1'b1;
                        state_r <= rbr_pkg::HOST_CMD;
                    end
                end
                rbr_pkg::HOST_CMD: begin
                    if (sent) begin
                        hostByte_r <= {2'h0, page_r};
                        state_r <= rbr_pkg::HOST_ARG;
                    end
                end
                rbr_pkg::HOST_ARG: begin
                    if (sent) begin
                        hostValid_r <= 1'b0;
                        hostReady_r <= 1'b1;
                        state_r <= rbr_pkg::HOST_ACK;
                    end
                end
                rbr_pkg::HOST_ACK: begin
                    if (got) begin
                        readOk_r <= ackGood;
                        byteIdx_r <= 4'h0;
                        if (ackGood) begin
                            state_r <= rbr_pkg::HOST_DATA;
                        end else begin
                            hostReady_r <= 1'b0;
                            busy_r <= 1'b0;
                            done_r <= 1'b1;
                            state_r <= rbr_pkg::HOST_IDLE;
                        end
                    end
                end
                rbr_pkg::HOST_DATA: begin
                    if (got) begin
                        dataByte_r <= rx;
                        dataValid_r <= 1'b1;
                        byteIdx_r <= byteIdx_r + 4'h1;
                        if (isLockByte) begin
                            // Read-only is sticky: a seen lock is cleared only by reset.
                            lockRo_r <= lockRo_r | lockRo;
                        end
                        if (byteIdx_r == lastIdx) begin
                            hostReady_r <= 1'b0;
                            busy_r <= 1'b0;
                            done_r <= 1'b1;
                            state_r <= rbr_pkg::HOST_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= rbr_pkg::HOST_IDLE;
                end
            endcase
        end
    end

    assign link.hostValid = hostValid_r;
    assign link.hostReady = hostReady_r;
    assign link.hostByte = hostByte_r;
    assign busy = busy_r;
    assign dataByte = dataByte_r;
    assign dataValid = dataValid_r;
    assign done = done_r;
    assign readOk = readOk_r;
    assign userPageWarn = warn_r;
    assign blockReadOnly = lockRo_r;
endmodule : rbr_host_end

// *** test/rbr_link_assertions.sv ***
`timescale 1ns/10ps
module rbr_link_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Link
    input wire logic [7:0] hostByte,
    input wire logic hostValid,
    input wire logic devReady,
    input wire logic [7:0] devByte,
    input wire logic devValid,
    input wire logic hostReady
);
    // --------
    // Command tracking
    // --------
    logic hostTake;
    logic devTake;
    logic argPhase_r;
    logic [1:0] argLow_r;
    logic [4:0] devCnt_r;
    logic ackOk_r;
    logic [4:0] lastIdx;
    assign hostTake = hostValid && devReady;
    assign devTake = devValid && hostReady;
    // The acknowledge is byte 0, so the last data byte carries the full count.
    assign lastIdx = 5'h10 - {1'b0, argLow_r, 2'h0};

    always_ff @(posedge clk) begin
        if (srst) begin
            argPhase_r <= 1'b0;
            argLow_r <= 2'h0;
            devCnt_r <= 5'h00;
            ackOk_r <= 1'b0;
        end else if (hostTake) begin
            argPhase_r <= !argPhase_r && hostByte == 8'h72;
            if (argPhase_r) begin
                argLow_r <= hostByte[1:0];
                devCnt_r <= 5'h00;
                ackOk_r <= 1'b0;
            end
        end else if (devTake) begin
            devCnt_r <= devCnt_r + 5'h01;
            if (devCnt_r == 5'h00) begin
                ackOk_r <= devByte[5:1] == 5'h0B;
            end
        end
    end

    // --------
    // Properties
    // --------
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (srst);

    property p_opcode;
        hostTake && !argPhase_r |-> hostByte == 8'h72;
    endproperty
    a_opcode: assert property (p_opcode) else $error("bad opcode byte");
    property p_replyBound;
        hostTake && argPhase_r |-> ##[1:300] devValid;
    endproperty
    a_replyBound: assert property (p_replyBound) else $error("no reply");
    property p_devQuiet;
        devValid |-> !devReady;
    endproperty
    a_devQuiet: assert property (p_devQuiet) else $error("ready while replying");
    property p_ackTop;
        devValid && devCnt_r == 5'h00 |-> devByte[7:6] == 2'b11;
    endproperty
    a_ackTop: assert property (p_ackTop) else $error("ack top bits wrong");
    property p_failAlone;
        devTake && devCnt_r == 5'h00 && devByte[5:1] != 5'h0B |=> !devValid [*4];
    endproperty
    a_failAlone: assert property (p_failAlone) else $error("data after fail");
    property p_countMax;
        devValid && ackOk_r |-> devCnt_r <= lastIdx;
    endproperty
    a_countMax: assert property (p_countMax) else $error("too many bytes");
    property p_lastStops;
        devTake && ackOk_r && devCnt_r == lastIdx |=> !devValid [*2];
    endproperty
    a_lastStops: assert property (p_lastStops) else $error("read past block");
    property p_holdHost;
        hostValid && !devReady |=> hostValid && $stable(hostByte);
    endproperty
    a_holdHost: assert property (p_holdHost) else $error("host byte dropped");
    property p_holdDev;
        devValid && !hostReady |=> devValid && $stable(devByte);
    endproperty
    a_holdDev: assert property (p_holdDev) else $error("reply byte dropped");

    c_ackOk: cover property (devTake && devCnt_r == 5'h00 && devByte[5:1] == 5'h0B);
    c_ackFail: cover property (devTake && devCnt_r == 5'h00 && devByte[5:1] != 5'h0B);
    c_short: cover property (devTake && ackOk_r && lastIdx == 5'h04 && devCnt_r == 5'h04);
endmodule : rbr_link_assertions

// *** test/testbench.sv ***
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic tagReq;
    logic [5:0] tagPage;
    logic tagAck = 1'b0;
    logic tagOk = 1'b0;
    logic [31:0] tagData = 32'h0;
    logic encOn = 1'b0;
    logic [31:0] seed = 32'h5A3C_9617;
    logic authWr = 1'b0;
    logic [1:0] authIdx = 2'h0;
    logic [31:0] authCode = 32'h0;
    logic authFail;
    logic startReq = 1'b0;
    logic [5:0] startPage = 6'h00;
    logic famS = 1'b0;
    logic famSLarge = 1'b0;
    logic [7:0] dataByte;
    logic dataValid, done, readOk, userPageWarn;
    logic [7:0] blockReadOnly;
    logic ce = 1'b1;
    logic hostBusy, devBusy;
    logic [31:0] mem [64];
    logic [1:0] waitCnt = 2'h0;
    logic [1:0] tagDelay = 2'h2;
    logic failOn = 1'b0;
    int n_fail = 0;
    int comparisons = 0;

    always #4 clk = ~clk;

    rbr_link_if link ();
    rbr_reader_end u_rbr_reader_end (.clk(clk), .srst(srst), .ce(ce), .link(link),
        .tagReq(tagReq), .tagPage(tagPage), .tagAck(tagAck), .tagOk(tagOk), .tagData(tagData),
        .encOn(encOn), .seed(seed), .authWr(authWr), .authIdx(authIdx), .authCode(authCode),
        .busy(devBusy), .authFail(authFail));
    rbr_host_end u_rbr_host_end (.clk(clk), .srst(srst), .ce(ce), .link(link),
        .startReq(startReq), .startPage(startPage), .famS(famS), .famSLarge(famSLarge),
        .busy(hostBusy), .dataByte(dataByte), .dataValid(dataValid), .done(done),
        .readOk(readOk),
        .userPageWarn(userPageWarn), .blockReadOnly(blockReadOnly));
    rbr_link_assertions u_rbr_link_assertions (.clk(clk), .srst(srst),
        .hostByte(link.hostByte), .hostValid(link.hostValid), .devReady(link.devReady),
        .devByte(link.devByte), .devValid(link.devValid), .hostReady(link.hostReady));

    // --------
    // Transponder model
    // --------
    // Idle data lines toggle so a stale word can never pass for a fresh one.
    always @(posedge clk) begin
        tagAck <= 1'b0;
        tagOk <= ~tagOk;
        tagData <= ~tagData;
        if (!tagReq || tagAck) begin
            waitCnt <= 2'h0;
        end else if (waitCnt == tagDelay) begin
            tagAck <= 1'b1;
            tagOk <= !(failOn && tagPage == 6'h12);
            tagData <= mem[tagPage] ^ ((encOn && tagPage >= 6'h04) ?
                seed ^ {mem[0][15:0], mem[0][31:16]} ^ {4{2'b00, tagPage}} : 32'h0);
        end else begin
            waitCnt <= waitCnt + 2'h1;
        end
    end

    // --------
    // Checking and host tasks
    // --------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_flag(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk_flag

    task automatic blk_read(input logic [5:0] pg, input logic expOk);
        int got;
        int t;
        logic [31:0] w;
        got = 0;
        t = 0;
        repeat (2) @(posedge clk);
        startPage <= pg;
        startReq <= 1'b1;
        @(posedge clk);
        startReq <= 1'b0;
        #1;
        chk_flag(hostBusy, 1'b1);
        do begin
            @(posedge clk);
            #1;
            t++;
            if (dataValid === 1'b1) begin
                w = mem[pg + got / 4];
                chk(dataByte, w[31 - 8 * (got % 4) -: 8]);
                got++;
            end
        end while (done !== 1'b1 && t < 500);
        chk_flag(done, 1'b1);
        chk_flag(hostBusy, 1'b0);
        chk_flag(devBusy, 1'b0);
        chk(got, expOk ? 16 - 4 * pg[1:0] : 0);
        chk_flag(readOk, expOk);
        chk_flag(userPageWarn, famS ? (pg < 2 || (!famSLarge && pg > 7)) : pg < 16);
        @(posedge clk);
    endtask : blk_read

    task automatic auth_load(input logic [1:0] idx, input logic [31:0] code);
        authIdx <= idx;
        authCode <= code;
        authWr <= 1'b1;
        @(posedge clk);
        authWr <= 1'b0;
    endtask : auth_load

    task automatic end_test(input string name);
        $display("test %s ended: comparisons=%0d n_fail=%0d", name, comparisons, n_fail);
    endtask : end_test

    task automatic tally_and_finish;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // --------
    // Tests
    // --------
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = {2'b00, i[5:0], 8'hA5 ^ i[7:0], 8'h3C, ~i[7:0]};
        end
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        for (int p = 16; p < 20; p++) blk_read(p[5:0], 1'b1);
        end_test("plain");
        encOn <= 1'b1;
        tagDelay <= 2'h0;
        for (int p = 2; p < 6; p++) blk_read(p[5:0], 1'b1);
        blk_read(6'h3F, 1'b1);
        end_test("cipher");
        encOn <= 1'b0;
        tagDelay <= 2'h2;
        mem[1][31:24] = 8'hFE;
        blk_read(6'h01, 1'b1);
        chk(blockReadOnly, 8'h80);
        mem[1][31:24] = 8'hBF;
        blk_read(6'h01, 1'b1);
        chk(blockReadOnly, 8'h82);
        end_test("lock");
        famS <= 1'b1;
        blk_read(6'h02, 1'b1);
        blk_read(6'h08, 1'b1);
        famSLarge <= 1'b1;
        blk_read(6'h08, 1'b1);
        famS <= 1'b0;
        blk_read(6'h0F, 1'b1);
        end_test("family");
        failOn <= 1'b1;
        blk_read(6'h10, 1'b0);
        failOn <= 1'b0;
        end_test("tag fault");
        auth_load(2'h0, 32'h1234_5678);
        blk_read(6'h14, 1'b0);
        chk_flag(authFail, 1'b1);
        auth_load(2'h1, mem[0]);
        blk_read(6'h14, 1'b1);
        chk_flag(authFail, 1'b0);
        end_test("authorisation");
        // A request offered while the clock enable is low must leave both ends idle.
        ce <= 1'b0;
        startReq <= 1'b1;
        repeat (3) @(posedge clk);
        startReq <= 1'b0;
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk_flag(hostBusy, 1'b0);
        chk_flag(devBusy, 1'b0);
        // A mid-run reset clears the seen locks and empties the authorisation list.
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk(blockReadOnly, 8'h00);
        blk_read(6'h14, 1'b1);
        end_test("freeze and reset");
        tally_and_finish();
    end

    // The whole run needs under a thousand cycles; this bound only catches a hang.
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end
endmodule : testbench
